// ==== rtl/suf_pkg.sv ====
// Constants, states and group table shared by the status upload framer.
`default_nettype none

package suf_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int HDR_BYTES = 6;
  localparam logic [7:0] PROTO_ID_BYTE = 8'h00;
  localparam logic [7:0] HDR_LEN_HI = 8'h00;
  localparam logic [7:0] HDR_LEN_BIAS = 8'h03;
  localparam logic [7:0] DEFAULT_STATION = 8'h01;
  localparam logic [7:0] UPLOAD_CODE = 8'h8b;
  localparam logic [7:0] GROUP_OVERHEAD = 8'h02;
  localparam int ID_MAX_CHARS = 20;
  localparam int ID_IW = 5;
  localparam logic [ID_IW-1:0] ID_MAX_LEN = 5'h14;

  // ----------------------------------------------------------------
  // Acknowledgement layout
  // ----------------------------------------------------------------
  localparam logic [2:0] ACK_LEN_HI_POS = 3'h4;
  localparam logic [2:0] ACK_LEN_LO_POS = 3'h5;
  localparam logic [2:0] ACK_ADDR_POS = 3'h6;
  localparam logic [2:0] ACK_CODE_POS = 3'h7;
  localparam logic [7:0] ACK_LEN_HI = 8'h00;
  localparam logic [7:0] ACK_LEN_LO = 8'h02;

  // ----------------------------------------------------------------
  // Group table, in emission order
  // ----------------------------------------------------------------
  localparam int NUM_GROUPS = 8;
  localparam logic [7:0] GROUP_TYPE [NUM_GROUPS] = '{
    8'h01, 8'h02, 8'h0b, 8'h0c, 8'h16, 8'h17, 8'h07, 8'h0d
  };
  localparam logic [NUM_GROUPS-1:0] GROUP_IS_ANA = 8'b1010_1100;
  localparam logic [1:0] GROUP_SLOT [NUM_GROUPS] = '{
    2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3
  };

  typedef enum logic [9:0] {
    ST_IDLE  = 10'b00_0000_0001,
    ST_HDR   = 10'b00_0000_0010,
    ST_ADDR  = 10'b00_0000_0100,
    ST_CODE  = 10'b00_0000_1000,
    ST_LEN   = 10'b00_0001_0000,
    ST_IDLEN = 10'b00_0010_0000,
    ST_IDSTR = 10'b00_0100_0000,
    ST_GTYPE = 10'b00_1000_0000,
    ST_GLEN  = 10'b01_0000_0000,
    ST_GDATA = 10'b10_0000_0000
  } suf_state_t;

endpackage : suf_pkg

`default_nettype wire

// ==== rtl/suf_fifo.sv ====
// Small byte FIFO between the frame builder and the outgoing stream.
`default_nettype none

module suf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } suf_fifo_regs_t;

  suf_fifo_regs_t st_reg;
  suf_fifo_regs_t st_next;
  logic push;
  logic pop;

  assign in_ready = (st_reg.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop)
    begin
      st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
    end
    if (push && !pop)
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule : suf_fifo

`default_nettype wire

// ==== rtl/suf_ack_check.sv ====
// Checker for the eight-byte acknowledgement returned by the server.
`default_nettype none

module suf_ack_check (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic clear,
  input wire logic [7:0] station,
  // Reply bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Result
  output logic ack_ok,
  output logic ack_err
);

  typedef struct packed {
    logic [2:0] pos;
    logic bad;
    logic ok;
    logic err;
  } suf_ack_regs_t;

  suf_ack_regs_t st_reg;
  suf_ack_regs_t st_next;
  logic byte_bad;

  assign ack_ok = st_reg.ok;
  assign ack_err = st_reg.err;

  // The transaction bytes are not compared: servers may echo any value there.
  always_comb
  begin
    unique case (st_reg.pos)
      suf_pkg::ACK_LEN_HI_POS: byte_bad = (rx_data != suf_pkg::ACK_LEN_HI);
      suf_pkg::ACK_LEN_LO_POS: byte_bad = (rx_data != suf_pkg::ACK_LEN_LO);
      suf_pkg::ACK_ADDR_POS: byte_bad = (rx_data != station);
      suf_pkg::ACK_CODE_POS: byte_bad = (rx_data != suf_pkg::UPLOAD_CODE);
      default: byte_bad = 1'b0;
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.ok = 1'b0;
    st_next.err = 1'b0;
    if (clear)
    begin
      st_next.pos = '0;
      st_next.bad = 1'b0;
    end
    else if (rx_valid)
    begin
      st_next.pos = st_reg.pos + 1'b1;
      st_next.bad = st_reg.bad || byte_bad;
      if (st_reg.pos == suf_pkg::ACK_CODE_POS)
      begin
        st_next.bad = 1'b0;
        st_next.ok = !(st_reg.bad || byte_bad);
        st_next.err = st_reg.bad || byte_bad;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule : suf_ack_check

`default_nettype wire

// ==== rtl/suf_framer.sv ====
// Status upload frame builder with output FIFO and reply checker.
`default_nettype none

module suf_framer #(
  parameter int MAX_DIG = 32,
  parameter int MAX_ANA = 8,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Frame request
  input wire logic start,
  output logic busy,
  output logic frame_done,
  // Frame configuration
  input wire logic [15:0] trans_id,
  input wire logic trans_id_auto,
  input wire logic addr_override,
  input wire logic [7:0] station_addr,
  input wire logic [suf_pkg::ID_IW-1:0] id_length,
  input wire logic [suf_pkg::ID_MAX_CHARS-1:0][7:0] id_chars,
  // Digital groups
  input wire logic [$clog2(MAX_DIG+1)-1:0] din_count,
  input wire logic [MAX_DIG-1:0] din_bits,
  input wire logic [$clog2(MAX_DIG+1)-1:0] dout_count,
  input wire logic [MAX_DIG-1:0] dout_bits,
  input wire logic [$clog2(MAX_DIG+1)-1:0] dflag_count,
  input wire logic [MAX_DIG-1:0] dflag_bits,
  input wire logic [$clog2(MAX_DIG+1)-1:0] blk_stat_count,
  input wire logic [MAX_DIG-1:0] blk_stat_bits,
  // Analogue groups
  input wire logic [$clog2(MAX_ANA+1)-1:0] ana_in_count,
  input wire logic [MAX_ANA-1:0][15:0] analog_input_values,
  input wire logic [$clog2(MAX_ANA+1)-1:0] ana_out_count,
  input wire logic [MAX_ANA-1:0][15:0] analog_output_values,
  input wire logic [$clog2(MAX_ANA+1)-1:0] ana_flag_count,
  input wire logic [MAX_ANA-1:0][15:0] analog_flag_values,
  input wire logic [$clog2(MAX_ANA+1)-1:0] blk_ana_count,
  input wire logic [MAX_ANA-1:0][15:0] block_analog_values,
  // Outgoing byte stream
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Reply byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic ack_ok,
  output logic ack_err,
  output logic ack_pending
);

  // ----------------------------------------------------------------
  // Local widths and state
  // ----------------------------------------------------------------
  localparam int DCW = $clog2(MAX_DIG + 1);
  localparam int ACW = $clog2(MAX_ANA + 1);
  localparam int DBW = $clog2(MAX_DIG / 8);
  localparam int AIW = $clog2(MAX_ANA);
  localparam int LAST_GRP = suf_pkg::NUM_GROUPS - 1;
  localparam int ID_W = suf_pkg::ID_IW;

  typedef struct packed {
    suf_pkg::suf_state_t state;
    logic [7:0] idx;
    logic [2:0] grp;
    logic [15:0] tid_cnt;
    logic done;
    logic pending;
  } suf_frm_regs_t;

  suf_frm_regs_t st_reg;
  suf_frm_regs_t st_next;

  logic [DCW-1:0] dig_cnt [4];
  logic [MAX_DIG-1:0] dig_bits [4];
  logic [MAX_DIG-1:0] dig_masked [4];
  logic [ACW-1:0] ana_cnt [4];
  logic [MAX_ANA-1:0][15:0] ana_val [4];
  logic [7:0] grp_len [suf_pkg::NUM_GROUPS];
  logic [7:0] frame_len, station, data_byte, emit_byte;
  logic [ID_W-1:0] id_len;
  logic [15:0] tid, ana_word;
  logic [1:0] slot;
  logic emit, fifo_ready, fire, accept;

  // ----------------------------------------------------------------
  // Group sources
  // ----------------------------------------------------------------
  assign dig_cnt = '{din_count, dout_count, dflag_count, blk_stat_count};
  assign dig_bits = '{din_bits, dout_bits, dflag_bits, blk_stat_bits};
  assign ana_cnt = '{ana_in_count, ana_out_count, ana_flag_count, blk_ana_count};
  assign ana_val = '{analog_input_values, analog_output_values, analog_flag_values,
    block_analog_values};

  // Points beyond the configured count read as zero so that padding bits
  // of the last byte never carry stale input levels.
  for (genvar s = 0; s < 4; s++)
  begin : g_mask
    for (genvar i = 0; i < MAX_DIG; i++)
    begin : g_bit
      assign dig_masked[s][i] = dig_bits[s][i] && (DCW'(i) < dig_cnt[s]);
    end
  end

  // ----------------------------------------------------------------
  // Lengths
  // ----------------------------------------------------------------
  always_comb
  begin
    id_len = (id_length > suf_pkg::ID_MAX_LEN) ? suf_pkg::ID_MAX_LEN : id_length;
    frame_len = 8'h01 + 8'(id_len);
    for (int g = 0; g < suf_pkg::NUM_GROUPS; g++)
    begin
      if (suf_pkg::GROUP_IS_ANA[g])
      begin
        grp_len[g] = 8'({ana_cnt[suf_pkg::GROUP_SLOT[g]], 1'b0});
      end
      else
      begin
        grp_len[g] = 8'((dig_cnt[suf_pkg::GROUP_SLOT[g]] + 8'h07) >> 3);
      end
      if (grp_len[g] != 8'h00)
      begin
        frame_len = frame_len + suf_pkg::GROUP_OVERHEAD + grp_len[g];
      end
    end
  end

  assign station = addr_override ? station_addr : suf_pkg::DEFAULT_STATION;
  assign tid = trans_id_auto ? st_reg.tid_cnt : trans_id;

  // ----------------------------------------------------------------
  // Current group data byte
  // ----------------------------------------------------------------
  assign slot = suf_pkg::GROUP_SLOT[st_reg.grp];
  assign ana_word = ana_val[slot][st_reg.idx[AIW:1]];

  always_comb
  begin
    if (suf_pkg::GROUP_IS_ANA[st_reg.grp])
    begin
      data_byte = st_reg.idx[0] ? ana_word[7:0] : ana_word[15:8];
    end
    else
    begin
      data_byte = dig_masked[slot][{st_reg.idx[DBW-1:0], 3'b000} +: 8];
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Configuration is not captured: it must hold steady while busy, saving a wide register.
  assign accept = start && (st_reg.state == suf_pkg::ST_IDLE);
  assign fire = emit && fifo_ready;

  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    emit = 1'b0;
    emit_byte = 8'h00;
    unique case (st_reg.state)
      suf_pkg::ST_IDLE:
      begin
        if (start)
        begin
          st_next.state = suf_pkg::ST_HDR;
          st_next.idx = 8'h00;
          st_next.grp = 3'h0;
        end
      end
      suf_pkg::ST_HDR:
      begin
        emit = 1'b1;
        unique case (st_reg.idx)
          8'h00: emit_byte = tid[15:8];
          8'h01: emit_byte = tid[7:0];
          8'h02: emit_byte = suf_pkg::PROTO_ID_BYTE;
          8'h03: emit_byte = suf_pkg::PROTO_ID_BYTE;
          8'h04: emit_byte = suf_pkg::HDR_LEN_HI;
          default: emit_byte = frame_len + suf_pkg::HDR_LEN_BIAS;
        endcase
        if (fire)
        begin
          st_next.idx = st_reg.idx + 8'h01;
          if (st_reg.idx == 8'(suf_pkg::HDR_BYTES - 1))
          begin
            st_next.state = suf_pkg::ST_ADDR;
          end
        end
      end
      suf_pkg::ST_ADDR:
      begin
        emit = 1'b1;
        emit_byte = station;
        if (fire)
        begin
          st_next.state = suf_pkg::ST_CODE;
        end
      end
      suf_pkg::ST_CODE:
      begin
        emit = 1'b1;
        emit_byte = suf_pkg::UPLOAD_CODE;
        if (fire)
        begin
          st_next.state = suf_pkg::ST_LEN;
        end
      end
      suf_pkg::ST_LEN:
      begin
        emit = 1'b1;
        emit_byte = frame_len;
        if (fire)
        begin
          st_next.state = suf_pkg::ST_IDLEN;
        end
      end
      suf_pkg::ST_IDLEN:
      begin
        emit = 1'b1;
        emit_byte = 8'(id_len);
        if (fire)
        begin
          st_next.idx = 8'h00;
          st_next.state = (id_len == '0) ? suf_pkg::ST_GTYPE : suf_pkg::ST_IDSTR;
        end
      end
      suf_pkg::ST_IDSTR:
      begin
        emit = 1'b1;
        emit_byte = id_chars[st_reg.idx[ID_W-1:0]];
        if (fire)
        begin
          st_next.idx = st_reg.idx + 8'h01;
          if (st_reg.idx == 8'(id_len) - 8'h01)
          begin
            st_next.state = suf_pkg::ST_GTYPE;
          end
        end
      end
      suf_pkg::ST_GTYPE:
      begin
        // An empty group costs one idle cycle and no bytes.
        if (grp_len[st_reg.grp] == 8'h00)
        begin
          if (st_reg.grp == 3'(LAST_GRP))
          begin
            st_next.state = suf_pkg::ST_IDLE;
            st_next.done = 1'b1;
          end
          else
          begin
            st_next.grp = st_reg.grp + 3'h1;
          end
        end
        else
        begin
          emit = 1'b1;
          emit_byte = suf_pkg::GROUP_TYPE[st_reg.grp];
          if (fire)
          begin
            st_next.state = suf_pkg::ST_GLEN;
          end
        end
      end
      suf_pkg::ST_GLEN:
      begin
        emit = 1'b1;
        emit_byte = grp_len[st_reg.grp];
        if (fire)
        begin
          st_next.idx = 8'h00;
          st_next.state = suf_pkg::ST_GDATA;
        end
      end
      suf_pkg::ST_GDATA:
      begin
        emit = 1'b1;
        emit_byte = data_byte;
        if (fire)
        begin
          st_next.idx = st_reg.idx + 8'h01;
          if (st_reg.idx == grp_len[st_reg.grp] - 8'h01)
          begin
            if (st_reg.grp == 3'(LAST_GRP))
            begin
              st_next.state = suf_pkg::ST_IDLE;
              st_next.done = 1'b1;
            end
            else
            begin
              st_next.grp = st_reg.grp + 3'h1;
              st_next.state = suf_pkg::ST_GTYPE;
            end
          end
        end
      end
      default:
      begin
        st_next.state = suf_pkg::ST_IDLE;
      end
    endcase
    // A reply landing in the same cycle as a new frame end leaves the
    // newer frame pending: the set wins.
    if (ack_ok || ack_err)
    begin
      st_next.pending = 1'b0;
    end
    if (st_next.done)
    begin
      st_next.tid_cnt = st_reg.tid_cnt + 16'h0001;
      st_next.pending = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= '{state: suf_pkg::ST_IDLE, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign busy = (st_reg.state != suf_pkg::ST_IDLE);
  assign frame_done = st_reg.done;
  assign ack_pending = st_reg.pending;

  // ----------------------------------------------------------------
  // Output buffer and reply checker
  // ----------------------------------------------------------------
  suf_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(emit),
    .in_ready(fifo_ready),
    .in_data(emit_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  suf_ack_check u_ack (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(accept),
    .station(station),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .ack_ok(ack_ok),
    .ack_err(ack_err)
  );

endmodule : suf_framer

`default_nettype wire

// ==== verification/suf_framer_checker.sv ====
// Port-level assertions for the status upload framer.
`default_nettype none

module suf_framer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request and stream
  input wire logic start,
  input wire logic busy,
  input wire logic frame_done,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  // Reply result
  input wire logic ack_ok,
  input wire logic ack_err,
  input wire logic ack_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // The byte position is tracked from the stream alone, so a lost byte shows up later.
  logic [7:0] idx_reg;
  logic [7:0] len_reg;
  logic take;
  assign take = tx_valid && tx_ready;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      idx_reg <= 8'h00;
      len_reg <= 8'h00;
    end
    else if (take)
    begin
      if (idx_reg == 8'h05)
        len_reg <= tx_data;
      idx_reg <= (idx_reg > 8'h05 && idx_reg == len_reg + 8'h05) ? 8'h00 : idx_reg + 8'h01;
    end
  end

  sequence s_take;
    start && !busy;
  endsequence
  sequence s_first_out;
    busy ##[0:2] tx_valid;
  endsequence

  property p_first;
    s_take |=> s_first_out;
  endproperty
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  property p_zero;
    take && (idx_reg inside {8'h02, 8'h03, 8'h04}) |-> tx_data == 8'h00;
  endproperty
  property p_code;
    take && idx_reg == 8'h07 |-> tx_data == 8'h8b;
  endproperty
  property p_len;
    take && idx_reg == 8'h08 |-> tx_data == len_reg - 8'h03;
  endproperty
  property p_done;
    frame_done |-> !busy ##1 ack_pending;
  endproperty
  property p_excl;
    ack_ok |-> !ack_err ##1 !ack_ok;
  endproperty
  property p_clr;
    (ack_ok || ack_err) && !frame_done |=> !ack_pending;
  endproperty

  a_first: assert property (p_first) else $error("no byte after start");
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  a_zero: assert property (p_zero) else $error("header byte not zero");
  a_code: assert property (p_code) else $error("upload code wrong");
  a_len: assert property (p_len) else $error("length byte wrong");
  a_done: assert property (p_done) else $error("pending not set");
  a_excl: assert property (p_excl) else $error("reply result overlap");
  a_clr: assert property (p_clr) else $error("pending not cleared");
endmodule : suf_framer_checker

bind suf_framer suf_framer_checker chk_u (.clk(clk), .sys_rst(sys_rst), .start(start),
  .busy(busy), .frame_done(frame_done), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .ack_ok(ack_ok), .ack_err(ack_err), .ack_pending(ack_pending));

`default_nettype wire

// ==== verification/suf_server_model.sv ====
// Behavioural server that takes upload frames and answers each one.
`default_nettype none

module suf_server_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Frame stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Reply stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Test controls
  input wire logic [7:0] station,
  input wire logic bad_reply,
  input wire logic hold_off
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  int flen = 0;
  int frames_in = 0;
  int frames_out = 0;
  int snd = 0;
  logic [31:0] rnd = 32'h0000_095a;

  // The frame end is found from the length byte, as a real server must.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      idx = 0;
    end
    else if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (idx == 5)
        flen = int'(tx_data) + 6;
      idx++;
      if (idx > 6 && idx == flen)
      begin
        idx = 0;
        frames_in++;
      end
    end
  end

  // An idle reply line toggles so that stale data never looks valid.
  always @(negedge clk)
  begin
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    tx_ready = !hold_off && (rnd[0] || rnd[2]);
    if (sys_rst)
    begin
      rx_valid = 1'b0;
      rx_data = 8'hff;
    end
    else if (frames_in != frames_out && snd < 8)
    begin
      rx_valid = 1'b1;
      rx_data = snd == 7 ? (bad_reply ? 8'h8a : 8'h8b) : snd == 6 ? station :
        snd == 5 ? 8'h02 : 8'h00;
      snd++;
    end
    else
    begin
      if (snd == 8)
      begin
        frames_out++;
        snd = 0;
      end
      rx_valid = 1'b0;
      rx_data = ~rx_data;
    end
  end
endmodule : suf_server_model

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the status upload framer.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic [15:0] trans_id = 16'h0009;
  logic trans_id_auto = 1'b0;
  logic addr_override = 1'b0;
  logic [7:0] station_addr = 8'h01;
  logic [4:0] id_length = 5'h00;
  logic [19:0][7:0] id_chars = '0;
  logic [5:0] cnt [8] = '{default: 6'h00};
  logic [31:0] dig [8] = '{default: 32'h0000_0000};
  logic [7:0][15:0] ana [8] = '{default: '0};
  logic bad_reply = 1'b0;
  logic hold_off = 1'b0;
  logic busy, frame_done, tx_valid, tx_ready, rx_valid, ack_ok, ack_err, ack_pending;
  logic [7:0] tx_data, rx_data;
  int errors = 0;
  int compares = 0;
  int frames = 0;
  int nok = 0;
  int nerr = 0;
  int ndone = 0;
  int gsz = 0;
  logic [31:0] seed = 32'h0000_095a;
  logic [7:0] got [$];
  logic [7:0] exp_q [$];
  localparam logic [7:0] GTYPE [8] = '{8'h01, 8'h02, 8'h0b, 8'h0c, 8'h16, 8'h17, 8'h07, 8'h0d};
  localparam logic [7:0] IS_ANA = 8'b1010_1100;

  always #10 clk = ~clk;

  suf_framer dut_u (.clk(clk), .sys_rst(sys_rst), .start(start), .busy(busy),
    .frame_done(frame_done), .trans_id(trans_id), .trans_id_auto(trans_id_auto),
    .addr_override(addr_override), .station_addr(station_addr), .id_length(id_length),
    .id_chars(id_chars), .din_count(cnt[0]), .din_bits(dig[0]), .dout_count(cnt[1]),
    .dout_bits(dig[1]), .dflag_count(cnt[4]), .dflag_bits(dig[4]),
    .blk_stat_count(cnt[6]), .blk_stat_bits(dig[6]), .ana_in_count(cnt[2][3:0]),
    .analog_input_values(ana[2]), .ana_out_count(cnt[3][3:0]), .analog_output_values(ana[3]),
    .ana_flag_count(cnt[5][3:0]), .analog_flag_values(ana[5]), .blk_ana_count(cnt[7][3:0]),
    .block_analog_values(ana[7]), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .ack_ok(ack_ok),
    .ack_err(ack_err), .ack_pending(ack_pending));

  suf_server_model srv_u (.clk(clk), .sys_rst(sys_rst), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .station(addr_override ? station_addr : 8'h01), .bad_reply(bad_reply), .hold_off(hold_off));

  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_data);
    if (ack_ok === 1'b1)
      nok++;
    if (ack_err === 1'b1)
      nerr++;
    if (frame_done === 1'b1)
      ndone++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("Error %0t: %s", $time, what);
    end
  endtask : chk

  task automatic stop_test();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic exp_build();
    logic [7:0] b [$];
    logic [15:0] tid;
    int il;
    int n;
    int k;
    il = id_length > 20 ? 20 : int'(id_length);
    tid = trans_id_auto ? frames[15:0] : trans_id;
    b.push_back(8'(il));
    for (int i = 0; i < il; i++)
      b.push_back(id_chars[i]);
    for (int g = 0; g < 8; g++)
    begin
      n = int'(cnt[g]);
      if (n == 0)
        continue;
      k = IS_ANA[g] ? n : (n + 7) / 8;
      b.push_back(GTYPE[g]);
      b.push_back(8'(IS_ANA[g] ? 2 * n : k));
      for (int j = 0; j < k; j++)
        if (IS_ANA[g])
          b = {b, ana[g][j][15:8], ana[g][j][7:0]};
        else
          b.push_back(dig[g][8*j +: 8] & (n - 8*j >= 8 ? 8'hff : 8'hff >> (8 - n + 8*j)));
    end
    exp_q = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(b.size() + 3),
      addr_override ? station_addr : 8'h01, 8'h8b, 8'(b.size())};
    exp_q = {exp_q, b};
  endtask : exp_build

  // A second start while busy must be ignored; the frame count proves it.
  task automatic run_frame(input string name);
    int w;
    int gb;
    int ok0;
    int err0;
    exp_build();
    gb = got.size();
    ok0 = nok;
    err0 = nerr;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk(busy === 1'b1, "busy not raised");
    repeat (3) @(negedge clk);
    start = busy;
    @(negedge clk);
    start = 1'b0;
    w = 0;
    while (nok + nerr == ok0 + err0 && w < 3000)
    begin
      @(negedge clk);
      w++;
    end
    repeat (4) @(negedge clk);
    frames++;
    chk(got.size() - gb == exp_q.size(), "frame length");
    foreach (exp_q[i]) chk(got[gb + i] === exp_q[i], "frame byte");
    chk(nok - ok0 == int'(!bad_reply) && nerr - err0 == int'(bad_reply), "reply result");
    chk(ndone == frames, "frame count");
    chk(ack_pending === 1'b0, "pending left set");
    $display("Test %s done", name);
  endtask : run_frame

  task automatic shuffle();
    seed = lfsr(seed);
    trans_id = seed[15:0];
    trans_id_auto = seed[16];
    addr_override = seed[17];
    id_length = seed[22:18];
    station_addr = seed[31:24];
    for (int i = 0; i < 20; i++)
    begin
      seed = lfsr(lfsr(seed));
      id_chars[i] = seed[7:0];
    end
    for (int g = 0; g < 8; g++)
    begin
      seed = lfsr(lfsr(lfsr(seed)));
      dig[g] = seed ^ {seed[15:0], seed[31:16]};
      ana[g] = {seed, ~seed, seed ^ 32'h5a5a_0f0f, {seed[7:0], seed[31:8]}};
      cnt[g] = seed[2:0] == 3'h0 ? 6'h00 : IS_ANA[g] ? 6'(seed[9:4] % 9) : 6'(seed[13:8] % 33);
    end
  endtask : shuffle

  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    id_length = 5'h14;
    for (int i = 0; i < 20; i++)
      id_chars[i] = 8'h41 + 8'(i);
    cnt = '{default: 6'h04};
    dig[0] = 32'h1;
    dig[1] = 32'hd;
    dig[4] = 32'h2;
    dig[6] = 32'h4;
    ana[2][0] = 16'h0080;
    ana[2][1] = 16'h0088;
    ana[3][2] = 16'h0080;
    ana[3][3] = 16'h0088;
    ana[5][0] = 16'h01c2;
    ana[5][2] = 16'h0226;
    ana[7][3] = 16'h01c2;
    run_frame("full groups");
    chk(got[8] === 8'h49 && got[1] === 8'h09, "length field");
    hold_off = 1'b1;
    gsz = got.size();
    fork
      begin
        repeat (30) @(negedge clk);
        chk(busy === 1'b1 && tx_valid === 1'b1 && got.size() == gsz, "stall");
        hold_off = 1'b0;
      end
    join_none
    run_frame("stalled sink");
    bad_reply = 1'b1;
    run_frame("bad reply");
    bad_reply = 1'b0;
    cnt = '{default: 6'h00};
    id_length = 5'h00;
    run_frame("empty groups");
    for (int k = 0; k < 12; k++)
    begin
      shuffle();
      run_frame("random");
    end
    stop_test();
  end
endmodule : testbench

`default_nettype wire
